// >>> inc/orp_map.svh
/*
 * Register offsets, field positions, reset values and counts of the
 * output reset pattern block. Assumes inclusion by bare name.
 */
`ifndef ORP_MAP_SVH
`define ORP_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define ORP_REG_CTRL      8'h00
`define ORP_REG_STATUS    8'h04
`define ORP_REG_MASK      8'h08
`define ORP_REG_SELECT    8'h0c
`define ORP_REG_PAT_LO    8'h10
`define ORP_REG_PAT_HI    8'h14
`define ORP_REG_COUNT     8'h18
`define ORP_REG_COMMIT    8'h1c
`define ORP_REG_LEVEL     8'h20
`define ORP_REG_STATE     8'h24

// ----------------------------------------
// Fields
// ----------------------------------------
`define ORP_CTRL_CLEAR    0
`define ORP_ST_DONE       0
`define ORP_ST_CFG_ERR    1
`define ORP_ST_SEL_ERR    2
`define ORP_ST_W          3

// ----------------------------------------
// Codes and geometry
// ----------------------------------------
`define ORP_CODE_OFF      2'h0
`define ORP_CODE_ON       2'h1
`define ORP_CODE_KEEP     2'h2
`define ORP_CODES         6'h20
`define ORP_ENTRIES       8'ha7
`define ORP_IDX_OPT1      8'h08
`define ORP_IDX_OPT2      8'h67
`define ORP_LAST_IDX      8'ha6
`define ORP_BASE_STD_TOP  13'h00e0
`define ORP_BASE_OPT1     13'h07d0
`define ORP_BASE_OPT1_TOP 13'h1390
`define ORP_BASE_OPT2     13'h1770
`define ORP_BASE_OPT2_TOP 13'h1f50
`define ORP_PAT_RESET     70'h20_0000_0000_0000_0000

`endif

// >>> inc/orp_pkg.sv
/*
 * Types of the output reset pattern block.
 * Assumes orp_map.svh for the numeric constants.
 */
package orp_pkg;
	typedef enum logic [1:0] {ORP_IDLE, ORP_READ, ORP_APPLY} orp_state_t;
	typedef enum logic [1:0] {ORP_M_POWER, ORP_M_RESET, ORP_M_CLEAR} orp_mode_t;
endpackage : orp_pkg

// >>> hw/orp_store.sv
/*
 * Small word store with one write port and one registered read port.
 * Assumes a single clock; contents load RESET_VAL once and survive rst_n.
 */
`timescale 1ns/1ps
`default_nettype none
module orp_store #(
	parameter int          WIDTH     = 32,
	parameter int          DEPTH     = 167,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Write port
	input  wire logic             we,
	input  wire logic [7:0]       waddr,
	input  wire logic [WIDTH-1:0] wdata,
	// Read port
	input  wire logic [7:0]       raddr,
	output logic      [WIDTH-1:0] rdata
);
	// Kept through rst_n like stored settings, so a bad entry is still
	// there to be flagged at the next power up
	logic [WIDTH-1:0] mem [DEPTH] = '{default: RESET_VAL};

	always_ff @(posedge clk) begin
		if (we && (int'(waddr) < DEPTH)) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) rdata <= '0;
		else rdata <= (int'(raddr) < DEPTH) ? mem[raddr] : '0;
	end
endmodule : orp_store
`default_nettype wire

// >>> hw/orp_top.sv
/*
 * Output reset pattern applier: stores per-output codes, sweeps all
 * entries on power up, on an output reset request and on a clear.
 * Assumes an AHB-Lite master on clk and an asynchronous reset pin.
 */
`include "orp_map.svh"
`timescale 1ns/1ps
`default_nettype none
module orp_top
	import orp_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Dedicated inputs
	input  wire logic        out_reset_req,
	// Output words
	output logic      [12:0] out_base,
	output logic      [31:0] out_levels,
	output logic             out_strobe,
	// Interrupt
	output logic             irq
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	orp_state_t        state;
	orp_mode_t         mode;
	logic [7:0]        idx;
	logic              pend_pu, pend_rst, pend_clr;
	logic [1:0]        req_sync;
	logic              req_prev;
	logic              req_rise;
	logic              a_act, a_wr;
	logic [7:0]        a_addr;
	logic [`ORP_ST_W-1:0] status, mask;
	logic [7:0]        sel_idx;
	logic [31:0]       pat_lo, pat_hi;
	logic [5:0]        pat_cnt;
	logic              wr_ok, commit;
	logic [69:0]       pat_rd;
	logic [31:0]       lvl_rd;
	logic [31:0]       next_levels;
	logic [7:0]        rd_addr;
	logic [`ORP_ST_W-1:0] ev;
	logic              sel_bad;
	logic [7:0]        next_sel;
	logic              lvl_ok;

	function automatic logic [12:0] orp_base_of(input logic [7:0] i);
		if (i < `ORP_IDX_OPT1) orp_base_of = {i[7:0], 5'h00};
		else if (i < `ORP_IDX_OPT2)
			orp_base_of = `ORP_BASE_OPT1 + {i - `ORP_IDX_OPT1, 5'h00};
		else orp_base_of = `ORP_BASE_OPT2 + {i - `ORP_IDX_OPT2, 5'h00};
	endfunction : orp_base_of

	// ----------------------------------------
	// Dedicated request input
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_sync <= 2'h0;
			req_prev <= 1'b0;
		end else begin
			req_sync <= {req_sync[0], out_reset_req};
			req_prev <= req_sync[1];
		end
	end
	assign req_rise = req_sync[1] && !req_prev;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	assign hresp     = 1'b0;
	// Level reads wait until the read port holds the selected entry again
	assign hreadyout = !(a_act && !a_wr && a_addr == `ORP_REG_LEVEL && !lvl_ok);
	assign wr_ok     = a_act && a_wr;
	assign commit    = wr_ok && a_addr == `ORP_REG_COMMIT;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			a_act  <= 1'b0;
			a_wr   <= 1'b0;
			a_addr <= 8'h00;
		end else if (hready) begin
			a_act  <= hsel && htrans[1];
			a_wr   <= hwrite;
			a_addr <= {haddr[7:2], 2'h0};
		end
	end

	// Read port is borrowed by a sweep and lags a new selection by a cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) lvl_ok <= 1'b0;
		else lvl_ok <= state == ORP_IDLE && !(wr_ok && a_addr == `ORP_REG_SELECT);
	end

	// Map a base output number to an entry index
	always_comb begin
		logic [12:0] n;
		logic [12:0] d;
		n = hwdata[12:0];
		d = 13'h0000;
		next_sel = sel_idx;
		sel_bad = 1'b0;
		if (n[4:0] == 5'h00 && n <= `ORP_BASE_STD_TOP) begin
			next_sel = {3'h0, n[9:5]};
		end else if (n >= `ORP_BASE_OPT1 && n <= `ORP_BASE_OPT1_TOP) begin
			d = n - `ORP_BASE_OPT1;
			next_sel = `ORP_IDX_OPT1 + {1'b0, d[11:5]};
			sel_bad = d[4:0] != 5'h00;
		end else if (n >= `ORP_BASE_OPT2 && n <= `ORP_BASE_OPT2_TOP) begin
			d = n - `ORP_BASE_OPT2;
			next_sel = `ORP_IDX_OPT2 + {2'h0, d[10:5]};
			sel_bad = d[4:0] != 5'h00;
		end else begin
			sel_bad = 1'b1;
		end
		if (sel_bad) next_sel = sel_idx;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_idx <= 8'h00;
			pat_lo  <= 32'h0000_0000;
			pat_hi  <= 32'h0000_0000;
			pat_cnt <= `ORP_CODES;
			mask    <= '0;
		end else if (wr_ok) begin
			if (a_addr == `ORP_REG_SELECT) sel_idx <= next_sel;
			else if (a_addr == `ORP_REG_PAT_LO) pat_lo <= hwdata;
			else if (a_addr == `ORP_REG_PAT_HI) pat_hi <= hwdata;
			else if (a_addr == `ORP_REG_COUNT) pat_cnt <= hwdata[5:0];
			else if (a_addr == `ORP_REG_MASK) mask <= hwdata[`ORP_ST_W-1:0];
		end
	end

	always_comb begin
		if (!a_act || a_wr) hrdata = 32'h0000_0000;
		else if (a_addr == `ORP_REG_STATUS) hrdata = {29'h0, status};
		else if (a_addr == `ORP_REG_MASK) hrdata = {29'h0, mask};
		else if (a_addr == `ORP_REG_SELECT) hrdata = {19'h0, orp_base_of(sel_idx)};
		else if (a_addr == `ORP_REG_PAT_LO) hrdata = pat_lo;
		else if (a_addr == `ORP_REG_PAT_HI) hrdata = pat_hi;
		else if (a_addr == `ORP_REG_COUNT) hrdata = {26'h0, pat_cnt};
		else if (a_addr == `ORP_REG_LEVEL) hrdata = lvl_rd;
		else if (a_addr == `ORP_REG_STATE) hrdata = {30'h0, state != ORP_IDLE, pend_pu};
		else hrdata = 32'h0000_0000;
	end

	// ----------------------------------------
	// Stores
	// ----------------------------------------
	assign rd_addr = (state == ORP_IDLE) ? sel_idx : idx;

	orp_store #(.WIDTH(70), .DEPTH(167), .RESET_VAL(`ORP_PAT_RESET)) u_pat (
		.clk   (clk),
		.rst_n (rst_n),
		.we    (commit),
		.waddr (sel_idx),
		.wdata ({pat_cnt, pat_hi, pat_lo}),
		.raddr (rd_addr),
		.rdata (pat_rd)
	);

	orp_store #(.WIDTH(32), .DEPTH(167), .RESET_VAL(32'h0000_0000)) u_lvl (
		.clk   (clk),
		.rst_n (rst_n),
		.we    (state == ORP_APPLY),
		.waddr (idx),
		.wdata (next_levels),
		.raddr (rd_addr),
		.rdata (lvl_rd)
	);

	// ----------------------------------------
	// Apply a pattern entry
	// ----------------------------------------
	always_comb begin
		logic [1:0] c;
		c = 2'h0;
		next_levels = 32'h0000_0000;
		for (int k = 0; k < 32; k++) begin
			c = pat_rd[2*k +: 2];
			if (c == `ORP_CODE_ON) next_levels[k] = 1'b1;
			else if (c == `ORP_CODE_KEEP && mode != ORP_M_POWER)
				next_levels[k] = lvl_rd[k];
			else next_levels[k] = 1'b0;
		end
	end

	// ----------------------------------------
	// Sweep sequencer
	// ----------------------------------------
	// Pending requests: a request that lands while one is taken survives
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_pu  <= 1'b1;
			pend_rst <= 1'b0;
			pend_clr <= 1'b0;
		end else begin
			if (state == ORP_IDLE && pend_pu) pend_pu <= 1'b0;
			if (req_rise) pend_rst <= 1'b1;
			else if (state == ORP_IDLE && !pend_pu && pend_rst) pend_rst <= 1'b0;
			if (wr_ok && a_addr == `ORP_REG_CTRL && hwdata[`ORP_CTRL_CLEAR])
				pend_clr <= 1'b1;
			else if (state == ORP_IDLE && !pend_pu && !pend_rst && pend_clr)
				pend_clr <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ORP_IDLE;
			mode  <= ORP_M_POWER;
			idx   <= 8'h00;
		end else begin
			case (state)
				ORP_IDLE: begin
					idx <= 8'h00;
					if (pend_pu || pend_rst || pend_clr) begin
						state <= ORP_READ;
						mode  <= pend_pu ? ORP_M_POWER : (pend_rst ? ORP_M_RESET : ORP_M_CLEAR);
					end
				end
				ORP_READ: state <= ORP_APPLY;
				ORP_APPLY: begin
					if (idx == `ORP_LAST_IDX) state <= ORP_IDLE;
					else begin
						idx   <= idx + 8'h01;
						state <= ORP_READ;
					end
				end
				default: state <= ORP_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_base   <= 13'h0000;
			out_levels <= 32'h0000_0000;
			out_strobe <= 1'b0;
		end else begin
			out_strobe <= state == ORP_APPLY;
			if (state == ORP_APPLY) begin
				out_base   <= orp_base_of(idx);
				out_levels <= next_levels;
			end
		end
	end

	// ----------------------------------------
	// Status and interrupt
	// ----------------------------------------
	always_comb begin
		ev = '0;
		ev[`ORP_ST_DONE] = state == ORP_APPLY && idx == `ORP_LAST_IDX;
		ev[`ORP_ST_CFG_ERR] = state == ORP_APPLY && mode == ORP_M_POWER
			&& pat_rd[69:64] != `ORP_CODES;
		ev[`ORP_ST_SEL_ERR] = wr_ok && a_addr == `ORP_REG_SELECT && sel_bad;
	end

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) status <= '0;
		else if (wr_ok && a_addr == `ORP_REG_STATUS)
			status <= (status & ~hwdata[`ORP_ST_W-1:0]) | ev;
		else status <= status | ev;
	end

	assign irq = |(status & mask);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_zero_off: assert property (@(posedge clk) disable iff (!rst_n)
		state == ORP_APPLY && mode == ORP_M_POWER && pat_rd[63:0] == 64'h0
		|=> out_strobe && out_levels == 32'h0000_0000)
		else $error("zero pattern did not give all off");
	a_req_start: assert property (@(posedge clk) disable iff (!rst_n)
		req_rise && state == ORP_IDLE && !pend_pu && !pend_clr && !pend_rst
		|=> state == ORP_IDLE ##1 state == ORP_READ && mode == ORP_M_RESET)
		else $error("output reset request did not start a sweep");
	a_left_lowest: assert property (@(posedge clk) disable iff (!rst_n)
		state == ORP_APPLY && pat_rd[1:0] == `ORP_CODE_ON && pat_rd[63:62] == `ORP_CODE_OFF
		|=> out_levels[0] && !out_levels[31])
		else $error("code order wrong");
	a_keep_hold: assert property (@(posedge clk) disable iff (!rst_n)
		state == ORP_APPLY && mode != ORP_M_POWER && pat_rd[41:40] == `ORP_CODE_KEEP
		|=> out_levels[20] == $past(lvl_rd[20]))
		else $error("keep code changed the level");
	a_keep_pwr: assert property (@(posedge clk) disable iff (!rst_n)
		state == ORP_APPLY && mode == ORP_M_POWER && pat_rd[41:40] == `ORP_CODE_KEEP
		|=> !out_levels[20])
		else $error("keep code came up on at power up");
	a_count_err: assert property (@(posedge clk) disable iff (!rst_n)
		state == ORP_APPLY && mode == ORP_M_POWER && pat_rd[69:64] != `ORP_CODES
		|=> status[`ORP_ST_CFG_ERR])
		else $error("bad code count not flagged");
	a_base_step: assert property (@(posedge clk) disable iff (!rst_n)
		state == ORP_APPLY && idx == `ORP_IDX_OPT1
		|=> out_strobe && out_base == `ORP_BASE_OPT1)
		else $error("first option entry base wrong");
	a_field_map: assert property (@(posedge clk) disable iff (!rst_n)
		wr_ok && a_addr == `ORP_REG_SELECT && hwdata[12:0] == `ORP_BASE_OPT2
		|=> sel_idx == `ORP_IDX_OPT2)
		else $error("fieldbus base did not select its entry");
endmodule : orp_top
`default_nettype wire

// >>> dv/orp_field_model.sv
/*
 * Field device model: latches every output word the block applies and
 * checks that entries arrive in index order.
 * Assumes out_base and out_levels are valid in the out_strobe cycle.
 */
`include "orp_map.svh"
`timescale 1ns/1ps
`default_nettype none
module orp_field_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Output words
	input  wire logic [12:0] out_base,
	input  wire logic [31:0] out_levels,
	input  wire logic        out_strobe,
	// Observation
	output logic      [15:0] strobes,
	output logic      [15:0] order_errs
);
	// ----------------------------------------
	// Output image and order check
	// ----------------------------------------
	logic [31:0] img [0:8191];
	logic [12:0] next_base;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			next_base  <= 13'h0000;
			strobes    <= 16'h0000;
			order_errs <= 16'h0000;
		end else if (out_strobe) begin
			img[out_base] <= out_levels;
			strobes       <= strobes + 16'h0001;
			// Gaps between ranges are jumped, not walked
			if (out_base !== next_base)
				order_errs <= order_errs + 16'h0001;
			case (out_base)
				`ORP_BASE_STD_TOP:  next_base <= `ORP_BASE_OPT1;
				`ORP_BASE_OPT1_TOP: next_base <= `ORP_BASE_OPT2;
				`ORP_BASE_OPT2_TOP: next_base <= 13'h0000;
				default:            next_base <= out_base + 13'h0020;
			endcase
		end
	end
endmodule : orp_field_model
`default_nettype wire

// >>> dv/tb_output_reset_pattern_apply.sv
/*
 * Self-checking bench of the output reset pattern block.
 * Assumes orp_top with an AHB-Lite slave and a field model.
 */
`include "orp_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_output_reset_pattern_apply;
	// ----------------------------------------
	// Signals, design and field model
	// ----------------------------------------
	logic        clk, rst_n, hsel, hwrite, hready, hresp, out_reset_req;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, out_levels, q;
	logic [12:0] out_base;
	logic        out_strobe, irq;
	logic [15:0] strobes, order_errs;
	int          errors, comparisons;

	orp_top orp_top_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .out_reset_req(out_reset_req),
		.out_base(out_base), .out_levels(out_levels), .out_strobe(out_strobe), .irq(irq));
	orp_field_model orp_field_model_i (.clk(clk), .rst_n(rst_n), .out_base(out_base),
		.out_levels(out_levels), .out_strobe(out_strobe), .strobes(strobes),
		.order_errs(order_errs));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict

	// A LEVEL read may stall for a whole sweep, so the wait is generous
	task automatic wait_ready;
		int n;
		n = 0;
		@(posedge clk);
		while (hready !== 1'b1 && n < 2000) begin
			n++;
			@(posedge clk);
		end
		if (n == 2000)
			check("hreadyout", 32'(hready), 32'h0000_0001);
	endtask : wait_ready

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		wait_ready();
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= d;
		wait_ready();
		q = hrdata;
		check("hresp", 32'(hresp), 32'h0000_0000);
	endtask : bus

	task automatic set_entry(input logic [31:0] base, input logic [31:0] lo, input logic [31:0] hi);
		bus(1'b1, `ORP_REG_SELECT, base);
		bus(1'b1, `ORP_REG_PAT_LO, lo);
		bus(1'b1, `ORP_REG_PAT_HI, hi);
		bus(1'b1, `ORP_REG_COUNT, 32'h0000_0020);
		bus(1'b1, `ORP_REG_COMMIT, 32'h0000_0000);
	endtask : set_entry

	task automatic wait_sweep(input logic [15:0] n0);
		int n;
		n = 0;
		while (strobes !== n0 + 16'h00a7 && n < 1000) begin
			n++;
			@(posedge clk);
		end
		repeat (10) @(posedge clk);
		check("strobes", 32'(strobes), 32'(n0) + 32'h0000_00a7);
		check("order", 32'(order_errs), 32'h0000_0000);
	endtask : wait_sweep

	function automatic logic [31:0] img(input logic [12:0] b);
		return orp_field_model_i.img[b];
	endfunction : img

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_power_up;
		logic [12:0] bases [5];
		bases = '{13'h0000, `ORP_BASE_STD_TOP, `ORP_BASE_OPT1, `ORP_BASE_OPT2, `ORP_BASE_OPT2_TOP};
		wait_sweep(16'h0000);
		for (int i = 0; i < 5; i++)
			check("power level", img(bases[i]), 32'h0000_0000);
		bus(1'b0, `ORP_REG_STATUS, 32'h0);
		check("status", q & 32'h7, 32'h0000_0001);
	endtask : t_power_up

	task automatic t_irq;
		check("irq masked", 32'(irq), 32'h0000_0000);
		bus(1'b1, `ORP_REG_MASK, 32'h0000_0001);
		@(posedge clk);
		check("irq raised", 32'(irq), 32'h0000_0001);
		bus(1'b1, `ORP_REG_STATUS, 32'h0000_0001);
		@(posedge clk);
		check("irq cleared", 32'(irq), 32'h0000_0000);
	endtask : t_irq

	// Outputs 10..12 and 20 on; entry 6000 output 0 on
	task automatic t_reset_req;
		logic [15:0] n0;
		set_entry(32'h0000_0000, 32'h0150_0000, 32'h0000_0100);
		set_entry(32'h0000_1770, 32'h0000_0001, 32'h0000_0000);
		n0 = strobes;
		out_reset_req <= 1'b1;
		repeat (4) @(posedge clk);
		out_reset_req <= 1'b0;
		wait_sweep(n0);
		check("entry 0", img(13'h0000), 32'h0010_1c00);
		check("entry 6000", img(13'h1770), 32'h0000_0001);
		bus(1'b1, `ORP_REG_SELECT, 32'h0000_0000);
		@(posedge clk);
		bus(1'b0, `ORP_REG_LEVEL, 32'h0);
		check("level reg", q, 32'h0010_1c00);
	endtask : t_reset_req

	// Output 20 now keeps its on level, output 10 goes off
	task automatic t_clear_keep;
		logic [15:0] n0;
		set_entry(32'h0000_0000, 32'h0140_0000, 32'h0000_0200);
		n0 = strobes;
		bus(1'b1, `ORP_REG_CTRL, 32'h0000_0001);
		wait_sweep(n0);
		check("keep entry", img(13'h0000), 32'h0010_1800);
	endtask : t_clear_keep

	task automatic t_refusals;
		bus(1'b1, `ORP_REG_SELECT, 32'h0000_0010);
		bus(1'b0, `ORP_REG_SELECT, 32'h0);
		check("select kept", q, 32'h0000_0000);
		bus(1'b0, `ORP_REG_STATUS, 32'h0);
		check("sel err", q & 32'h4, 32'h0000_0004);
		bus(1'b1, 8'h30, 32'hffff_ffff);
		bus(1'b0, 8'h30, 32'h0);
		check("unmapped", q, 32'h0000_0000);
		bus(1'b1, `ORP_REG_STATUS, 32'h0000_0007);
		bus(1'b0, `ORP_REG_STATE, 32'h0);
		check("idle state", q, 32'h0000_0000);
	endtask : t_refusals

	// Patterns survive rst_n: keep codes start off, a short entry flags
	task automatic t_second_reset;
		bus(1'b1, `ORP_REG_SELECT, 32'h0000_07d0);
		bus(1'b1, `ORP_REG_COUNT, 32'h0000_001f);
		bus(1'b1, `ORP_REG_COMMIT, 32'h0000_0000);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		wait_sweep(16'h0000);
		check("repower", img(13'h0000), 32'h0000_1800);
		check("repower 2000", img(13'h07d0), 32'h0000_1800);
		bus(1'b0, `ORP_REG_STATUS, 32'h0);
		check("cfg err", q & 32'h7, 32'h0000_0003);
	endtask : t_second_reset

	initial begin
		errors        = 0;
		comparisons   = 0;
		rst_n         = 1'b0;
		hsel          = 1'b0;
		haddr         = 8'h00;
		htrans        = 2'h0;
		hwrite        = 1'b0;
		hsize         = 3'h2;
		hwdata        = 32'h0000_0000;
		out_reset_req = 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_power_up();
		t_irq();
		t_reset_req();
		t_clear_keep();
		t_refusals();
		t_second_reset();
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		give_verdict();
	end
endmodule : tb_output_reset_pattern_apply
`default_nettype wire
